/* design/adc_seq_regs.svh */
// Purpose: register offsets, field positions and reset values of the converter sequencer
// Assumes: 32-bit register accesses at byte offsets
// Notes:   definitions only
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define REG_ADDR_W       8
`define REG_BASE_CLK     8'h0c
`define REG_START_DIV    8'h10
`define REG_SCAN_DIV     8'h14
`define REG_GAIN_LO      8'h18
`define REG_GAIN_HI      8'h1c
`define REG_CTRL0        8'h38
`define REG_CTRL1        8'h3c

`define REG_RESET        32'h0000_0000
`define BASE_CLK_HZ      32'h05f5_e100
`define CTL_WRITE_MASK   32'h0005_0377

`define CTL_LAST_LSB     0
`define CTL_LAST_MSB     2
`define CTL_GAIN_LSB     4
`define CTL_GAIN_MSB     6
`define CTL_SEQ_LSB      8
`define CTL_SEQ_MSB      9
`define CTL_START_BIT    16
`define CTL_SCAN_BIT     18
`define STS_ARMED_BIT    20
`define STS_RUN_BIT      21
`define STS_SCAN_BIT     22
`define STS_STEP_LSB     24
`define STS_STEP_MSB     26

`define GAIN_NIBBLE_W    4

`endif

/* design/adc_seq_pkg.sv */
// Purpose: shared types of the converter sequencer
// Assumes: two converters, eight channels each
// Notes:   offsets and field positions live in adc_seq_regs.svh
package adc_seq_pkg;

	localparam int NUM_CONV = 2;

	typedef logic [2:0] chan_t;
	typedef logic [3:0] gain_t;

	typedef enum logic [1:0] {
		SEQ_SINGLE   = 2'h0,
		SEQ_MODIFY   = 2'h1,
		SEQ_ADVANCED = 2'h2,
		SEQ_BASIC    = 2'h3
	} seq_mode_t;

	typedef enum logic [1:0] {
		ACQ_IDLE,
		ACQ_ARMED,
		ACQ_RUNNING
	} acq_state_t;

endpackage : adc_seq_pkg

/* design/rate_if.sv */
// Purpose: carrier between the sequencer and its rate dividers
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
interface rate_if;
	logic [31:0] divisor;
	logic        run;
	logic        restart;
	logic        tick;

	modport timer (input divisor, input run, input restart, output tick);
	modport user  (output divisor, output run, output restart, input tick);
endinterface : rate_if

/* design/rate_divider.sv */
// Purpose: divides the base sequencer clock by a register value
// Assumes: base clock is clk
// Notes:   a divisor of zero never ticks
`timescale 1ns/1ps
module rate_divider (
	input  wire logic clk,
	input  wire logic rst,
	rate_if.timer     rate
);
	logic [31:0] count;

	// the restart cycle counts as the first of the period, since the starter already fired one event;
	// a divisor lowered below the running count ends the period at once instead of wrapping
	always_ff @(posedge clk) begin
		if (rst || rate.divisor == 32'h0) begin
			count     <= 32'h0;
			rate.tick <= 1'b0;
		end else if (rate.restart) begin
			count     <= (rate.divisor == 32'h1) ? 32'h0 : 32'h1;
			rate.tick <= rate.divisor == 32'h1;
		end else if (!rate.run) begin
			count     <= 32'h0;
			rate.tick <= 1'b0;
		end else if (count >= 32'(rate.divisor - 32'h1)) begin
			count     <= 32'h0;
			rate.tick <= 1'b1;
		end else begin
			count     <= 32'(count + 32'h1);
			rate.tick <= 1'b0;
		end
	end
endmodule : rate_divider

/* design/pin_edge_detect.sv */
// Purpose: synchronises a digital input and reports its selected edge
// Assumes: pin is asynchronous to clk
// Notes:   pulse is one cycle, three cycles after the pin moves
`timescale 1ns/1ps
module pin_edge_detect (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	input  wire logic rising_sel,
	input  wire logic enable,
	output logic      pulse
);
	logic       meta;
	logic       sync;
	logic       last;
	logic [1:0] settle;

	// edges count only once the whole chain holds pin samples, so a pin idling high
	// does not look like a rising edge right after reset
	always_ff @(posedge clk) begin
		if (rst)
			settle <= 2'h0;
		else if (!(&settle))
			settle <= 2'(settle + 2'h1);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			last <= sync;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			pulse <= 1'b0;
		else
			pulse <= enable && (&settle) && (rising_sel ? (sync && !last) : (!sync && last));
	end
endmodule : pin_edge_detect

/* design/adc_sequencer_start_control.sv */
// Purpose: channel sequencing and start timing for two converter front ends
// Assumes: registers reached with 32-bit accesses at byte offsets; one 100 MHz clock
// Notes:   trigger and start inputs are asynchronous pins; their enables come from local logic
//
// Function
// - each converter has its own mode field
// - mode 00 converts last channel, common gain
// - mode 01 edits settings without restarting stepping
// - mode 10 steps channels using per-channel gains
// - advanced sequence wraps to channel zero
// - mode 11 steps and wraps, common gain
// - zero divisor: start bit gives one event
// - nonzero divisor: first register's start bit starts now, then periodic
// - nonzero divisor, trigger enabled: first register's start bit only arms
// - periodic runs until stop write or reset
// - external start edge gives one event
// - single mode: one channel per event
// - scan mode: whole sequence per event
// - scan channels paced by second divisor
// - scan ignored for mode 00 or last zero
// - start rate is base clock over divisor
// - one gain nibble per channel
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module adc_sequencer_start_control
	import adc_seq_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [`REG_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	output logic      [31:0]            reg_rdata,
	output logic                        reg_rvalid,
	input  wire logic                   ext_trig_enable,
	input  wire logic                   ext_trig_rising,
	input  wire logic                   ext_trig_pin,
	input  wire logic                   ext_start_enable,
	input  wire logic                   ext_start_rising,
	input  wire logic                   ext_start_pin,
	output logic      [NUM_CONV-1:0]    conv_start,
	output chan_t     [NUM_CONV-1:0]    conv_channel,
	output gain_t     [NUM_CONV-1:0]    conv_gain
);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// registers

	logic       [31:0] start_rate_divisor;
	logic       [31:0] scan_channel_rate_divisor;
	logic       [31:0] gain_codes_low_channels;
	logic       [31:0] gain_codes_high_channels;
	logic       [31:0] converter_zero_control;
	logic       [31:0] converter_one_control;
	acq_state_t        acq_state;

	logic wr_start_div;
	logic wr_scan_div;
	logic wr_gain_lo;
	logic wr_gain_hi;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wdata_start;

	assign wr_start_div = reg_wr && reg_addr == `REG_START_DIV;
	assign wr_scan_div  = reg_wr && reg_addr == `REG_SCAN_DIV;
	assign wr_gain_lo   = reg_wr && reg_addr == `REG_GAIN_LO;
	assign wr_gain_hi   = reg_wr && reg_addr == `REG_GAIN_HI;
	assign wr_ctrl0     = reg_wr && reg_addr == `REG_CTRL0;
	assign wr_ctrl1     = reg_wr && reg_addr == `REG_CTRL1;
	assign wdata_start  = reg_wdata[`CTL_START_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			start_rate_divisor        <= `REG_RESET;
			scan_channel_rate_divisor <= `REG_RESET;
			gain_codes_low_channels   <= `REG_RESET;
			gain_codes_high_channels  <= `REG_RESET;
		end else begin
			if (wr_start_div)
				start_rate_divisor <= reg_wdata;
			if (wr_scan_div)
				scan_channel_rate_divisor <= reg_wdata;
			if (wr_gain_lo)
				gain_codes_low_channels <= reg_wdata;
			if (wr_gain_hi)
				gain_codes_high_channels <= reg_wdata;
		end
	end

	// only defined control fields are kept so reserved bits read back as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			converter_zero_control <= `REG_RESET;
			converter_one_control  <= `REG_RESET;
		end else begin
			if (wr_ctrl0)
				converter_zero_control <= reg_wdata & `CTL_WRITE_MASK;
			if (wr_ctrl1)
				converter_one_control <= reg_wdata & `CTL_WRITE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// effective control fields

	// a control write steers the start event it raises, so that cycle reads the write data;
	// using only the stored copy would run that event with the previous settings
	logic [31:0] ctrl0_eff;
	logic [31:0] ctrl1_eff;
	logic        scan_req;

	assign ctrl0_eff = wr_ctrl0 ? (reg_wdata & `CTL_WRITE_MASK) : converter_zero_control;
	assign ctrl1_eff = wr_ctrl1 ? (reg_wdata & `CTL_WRITE_MASK) : converter_one_control;
	assign scan_req  = ctrl0_eff[`CTL_SCAN_BIT];

	////////////////////////////////////////////////////////////////////////////////////////////////
	// start event sources

	logic trig_pulse;
	logic ext_start_pulse;
	logic div_zero;
	logic sw_evt;
	logic trig_evt;
	logic timer_evt;
	logic start_evt;
	logic scan_tick;
	logic any_scanning;

	rate_if start_rate ();
	rate_if scan_rate ();

	pin_edge_detect u_trig_edge (
		.clk        (clk),
		.rst        (rst),
		.pin        (ext_trig_pin),
		.rising_sel (ext_trig_rising),
		.enable     (ext_trig_enable),
		.pulse      (trig_pulse)
	);

	pin_edge_detect u_start_edge (
		.clk        (clk),
		.rst        (rst),
		.pin        (ext_start_pin),
		.rising_sel (ext_start_rising),
		.enable     (ext_start_enable),
		.pulse      (ext_start_pulse)
	);

	assign div_zero = start_rate_divisor == `REG_RESET;

	// software start: either control register when untimed, only the first one when timed and the trigger is disabled
	assign sw_evt = ((wr_ctrl0 || wr_ctrl1) && wdata_start && div_zero)
		|| (wr_ctrl0 && wdata_start && !div_zero && !ext_trig_enable);

	// a write to the first control register in the same cycle overrides a pending trigger
	assign trig_evt  = acq_state == ACQ_ARMED && trig_pulse && !wr_ctrl0;
	assign timer_evt = acq_state == ACQ_RUNNING && start_rate.tick;
	assign start_evt = sw_evt || trig_evt || timer_evt || ext_start_pulse;

	// a stop write also drops an armed trigger, so a late edge cannot restart the run
	always_ff @(posedge clk) begin
		if (rst) begin
			acq_state <= ACQ_IDLE;
		end else if (wr_ctrl0) begin
			if (!wdata_start || div_zero)
				acq_state <= ACQ_IDLE;
			else if (ext_trig_enable)
				acq_state <= ACQ_ARMED;
			else
				acq_state <= ACQ_RUNNING;
		end else if (trig_evt) begin
			acq_state <= ACQ_RUNNING;
		end
	end

	// the base sequencer clock is clk itself, so the rate is clk over the divisor
	assign start_rate.divisor = start_rate_divisor;
	assign start_rate.run     = acq_state == ACQ_RUNNING;
	assign start_rate.restart = sw_evt || trig_evt;

	rate_divider u_start_rate (
		.clk  (clk),
		.rst  (rst),
		.rate (start_rate.timer)
	);

	assign scan_rate.divisor = scan_channel_rate_divisor;
	assign scan_rate.run     = any_scanning;
	// every start event restarts the scan timer so each scan keeps its own channel spacing
	assign scan_rate.restart = start_evt;
	assign scan_tick         = scan_rate.tick;

	rate_divider u_scan_rate (
		.clk  (clk),
		.rst  (rst),
		.rate (scan_rate.timer)
	);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// per-converter channel stepping

	logic  [NUM_CONV-1:0] scanning_vec;
	chan_t [NUM_CONV-1:0] step_vec;

	assign any_scanning = |scanning_vec;

	for (genvar i = 0; i < NUM_CONV; i++) begin : g_conv
		logic      [31:0] ctrl;
		logic      [31:0] gains;
		seq_mode_t        mode;
		chan_t            last;
		logic      [2:0]  cgain;
		logic             scan_eff;
		logic             step_clear;
		chan_t            step;
		chan_t            cur;
		chan_t            ch;
		logic             scanning;
		logic             scan_fire;
		logic             fire;

		assign ctrl    = (i == 0) ? ctrl0_eff : ctrl1_eff;
		assign gains   = (i == 0) ? gain_codes_low_channels : gain_codes_high_channels;
		assign mode    = seq_mode_t'(ctrl[`CTL_SEQ_MSB:`CTL_SEQ_LSB]);
		assign last    = ctrl[`CTL_LAST_MSB:`CTL_LAST_LSB];
		assign cgain   = ctrl[`CTL_GAIN_MSB:`CTL_GAIN_LSB];

		// the scan bit belongs to the first control register and serves both converters
		assign scan_eff = scan_req
			&& mode != SEQ_SINGLE && last != chan_t'(0);

		// a start, arm or stop write rewinds the stepping unless the new mode only edits settings
		assign step_clear = (wr_ctrl0 || (wr_ctrl1 && wdata_start))
			&& mode != SEQ_MODIFY;

		assign cur       = step_clear ? chan_t'(0) : step;
		assign scan_fire = scanning && scan_tick && !step_clear;
		assign fire      = start_evt || scan_fire;
		// every scan begins at channel zero even if single steps left the counter elsewhere
		assign ch        = (start_evt && scan_eff) ? chan_t'(0) : cur;

		always_ff @(posedge clk) begin
			if (rst) begin
				step     <= chan_t'(0);
				scanning <= 1'b0;
			end else if (start_evt && mode != SEQ_SINGLE) begin
				if (scan_eff) begin
					step     <= chan_t'(1);
					scanning <= 1'b1;
				end else begin
					step     <= (cur >= last) ? chan_t'(0) : chan_t'(cur + chan_t'(1));
					scanning <= 1'b0;
				end
			end else if (scan_fire) begin
				// a last channel lowered below the current step wraps the next step to zero
				step     <= (cur >= last) ? chan_t'(0) : chan_t'(cur + chan_t'(1));
				scanning <= cur < last;
			end else if (step_clear || (start_evt && mode == SEQ_SINGLE)) begin
				step     <= chan_t'(0);
				scanning <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				conv_start[i]   <= 1'b0;
				conv_channel[i] <= chan_t'(0);
				conv_gain[i]    <= gain_t'(0);
			end else begin
				conv_start[i] <= fire;
				// channel and gain hold after the pulse so a slow front end may sample them late
				if (fire) begin
					unique case (mode)
						SEQ_SINGLE: begin
							conv_channel[i] <= last;
							conv_gain[i]    <= {1'b0, cgain};
						end
						SEQ_ADVANCED: begin
							conv_channel[i] <= ch;
							conv_gain[i]    <= gains[{ch, 2'h0} +: `GAIN_NIBBLE_W];
						end
						SEQ_MODIFY, SEQ_BASIC: begin
							conv_channel[i] <= ch;
							conv_gain[i]    <= {1'b0, cgain};
						end
					endcase
				end
			end
		end

		assign scanning_vec[i] = scanning;
		assign step_vec[i]     = step;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// register read-back

	logic [31:0] sts0;
	logic [31:0] sts1;

	// live status is merged into the control words; these bits are never stored
	always_comb begin
		sts0                                  = converter_zero_control;
		sts0[`STS_ARMED_BIT]                  = acq_state == ACQ_ARMED;
		sts0[`STS_RUN_BIT]                    = acq_state == ACQ_RUNNING;
		sts0[`STS_SCAN_BIT]                   = scanning_vec[0];
		sts0[`STS_STEP_MSB:`STS_STEP_LSB]     = step_vec[0];
		sts1                                  = converter_one_control;
		sts1[`STS_SCAN_BIT]                   = scanning_vec[1];
		sts1[`STS_STEP_MSB:`STS_STEP_LSB]     = step_vec[1];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rvalid <= 1'b0;
			reg_rdata  <= `REG_RESET;
		end else begin
			reg_rvalid <= reg_rd;
			// read data holds until the next read so software may fetch it late
			if (reg_rd) begin
				unique case (reg_addr)
					`REG_BASE_CLK:  reg_rdata <= `BASE_CLK_HZ;
					`REG_START_DIV: reg_rdata <= start_rate_divisor;
					`REG_SCAN_DIV:  reg_rdata <= scan_channel_rate_divisor;
					`REG_GAIN_LO:   reg_rdata <= gain_codes_low_channels;
					`REG_GAIN_HI:   reg_rdata <= gain_codes_high_channels;
					`REG_CTRL0:     reg_rdata <= sts0;
					`REG_CTRL1:     reg_rdata <= sts1;
					default:        reg_rdata <= `REG_RESET;
				endcase
			end
		end
	end

endmodule : adc_sequencer_start_control

/* dv/conv_front_model.sv */
// Purpose: stands in for one converter front end, logging each commanded conversion
// Assumes: a conversion command is a one-cycle pulse
// Notes:   the bench pops the queues; a reset empties them
`timescale 1ns/1ps
module conv_front_model
	import adc_seq_pkg::*;
(
	input wire logic  clk,
	input wire logic  rst,
	input wire logic  start,
	input wire chan_t channel,
	input wire gain_t gain
);
	chan_t ch_q[$];
	gain_t g_q[$];
	int    t_q[$];
	int    cyc = 0;

	////////////////////////////////////////////////////////////////
	// cycle stamps let the bench measure start spacing
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rst) begin
			ch_q.delete();
			g_q.delete();
			t_q.delete();
		end else if (start === 1'b1) begin
			ch_q.push_back(channel);
			g_q.push_back(gain);
			t_q.push_back(cyc);
		end
	end
endmodule : conv_front_model

/* dv/adc_seq_monitor.sv */
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock, synchronous active-high reset
// Notes:   register values are shadowed from the write strobe
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module adc_seq_monitor
	import adc_seq_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [`REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0]            reg_wdata,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   reg_rvalid,
	input wire logic                   ext_trig_enable,
	input wire logic                   ext_start_enable,
	input wire logic [NUM_CONV-1:0]    conv_start,
	input wire chan_t [NUM_CONV-1:0]   conv_channel,
	input wire gain_t [NUM_CONV-1:0]   conv_gain
);
	logic [31:0] div;
	logic [31:0] gain_lo;
	logic [31:0] gain_hi;
	logic [31:0] ctl0;
	logic [31:0] ctl1;
	chan_t       prev0;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			div <= '0;
			gain_lo <= '0;
			gain_hi <= '0;
			ctl0 <= '0;
			ctl1 <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`REG_START_DIV: div <= reg_wdata;
				`REG_GAIN_LO: gain_lo <= reg_wdata;
				`REG_GAIN_HI: gain_hi <= reg_wdata;
				`REG_CTRL0: ctl0 <= reg_wdata & `CTL_WRITE_MASK;
				`REG_CTRL1: ctl1 <= reg_wdata & `CTL_WRITE_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) prev0 <= '0;
		else if (conv_start[0]) prev0 <= conv_channel[0];
	end

	////////////////////////////////////////////////////////////////
	sw_once_a: assert property (reg_wr && reg_wdata[16] && div == '0 &&
		(reg_addr == `REG_CTRL0 || reg_addr == `REG_CTRL1) |=> conv_start == 2'b11)
		else $error("software start gave no conversion");
	arm_quiet_a: assert property (reg_wr && reg_addr == `REG_CTRL0 && reg_wdata[16] &&
		!reg_wdata[18] && div != '0 && ext_trig_enable && !ext_start_enable |=> conv_start == 2'b00)
		else $error("arming started a conversion");
	single_mode_a: assert property (conv_start[0] && ctl0[9:8] == 2'h0 |->
		conv_channel[0] == ctl0[2:0] && conv_gain[0] == {1'b0, ctl0[6:4]})
		else $error("single mode channel or gain wrong");
	common_gain_a: assert property (conv_start[1] && ctl1[8] |-> conv_gain[1] == {1'b0, ctl1[6:4]})
		else $error("common gain not used");
	adv_gain_a: assert property (conv_start[0] && ctl0[9:8] == 2'h2 |->
		conv_gain[0] == gain_lo[{conv_channel[0], 2'b00} +: 4])
		else $error("channel gain wrong on converter zero");
	hi_gain_a: assert property (conv_start[1] && ctl1[9:8] == 2'h2 |->
		conv_gain[1] == gain_hi[{conv_channel[1], 2'b00} +: 4])
		else $error("channel gain wrong on converter one");
	wrap_zero_a: assert property (conv_start[0] && ctl0[9] && prev0 == ctl0[2:0] |-> conv_channel[0] == 3'h0)
		else $error("stepping did not wrap");
	mode_read_a: assert property (reg_rd && reg_addr == `REG_CTRL1 |=>
		reg_rvalid && reg_rdata[9:8] == ctl1[9:8])
		else $error("mode field read back wrong");
	base_clk_a: assert property (reg_rd && reg_addr == `REG_BASE_CLK |=> reg_rvalid && reg_rdata == `BASE_CLK_HZ)
		else $error("base clock read wrong");
	div_read_a: assert property (reg_rd && reg_addr == `REG_START_DIV |=> reg_rdata == div)
		else $error("divisor read back wrong");
endmodule : adc_seq_monitor

/* dv/testbench.sv */
// Purpose: directed scenarios for the converter sequencer
// Assumes: 100 MHz clock, inputs moved 1 ns after the rising edge
// Notes:   conversions are collected by two front-end models
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module testbench
	import adc_seq_pkg::*;
;
	logic                    clk;
	logic                    rst = 1'b1;
	logic                    reg_wr = 1'b0;
	logic                    reg_rd = 1'b0;
	logic [7:0]              reg_addr = 8'h00;
	logic [31:0]             reg_wdata = 32'h0;
	logic [31:0]             reg_rdata;
	logic                    reg_rvalid;
	logic                    ext_trig_enable = 1'b0;
	logic                    ext_trig_rising = 1'b0;
	logic                    ext_trig_pin = 1'b1;
	logic                    ext_start_enable = 1'b0;
	logic                    ext_start_rising = 1'b1;
	logic                    ext_start_pin = 1'b0;
	logic [NUM_CONV-1:0]     conv_start;
	chan_t [NUM_CONV-1:0]    conv_channel;
	gain_t [NUM_CONV-1:0]    conv_gain;
	int                      error_cnt = 0;
	int                      check_count = 0;
	int                      last_t = 0;

	adc_sequencer_start_control adc_sequencer_start_control_i (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .ext_trig_enable, .ext_trig_rising, .ext_trig_pin,
		.ext_start_enable, .ext_start_rising, .ext_start_pin, .conv_start, .conv_channel, .conv_gain);
	conv_front_model m0_i (.clk, .rst, .start(conv_start[0]), .channel(conv_channel[0]), .gain(conv_gain[0]));
	conv_front_model m1_i (.clk, .rst, .start(conv_start[1]), .channel(conv_channel[1]), .gain(conv_gain[1]));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic results();
		if (error_cnt == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reset_dut();
		rst = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
	endtask : reset_dut

	// strobe drops a cycle before the next request so it never toggles twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		check(reg_rvalid, 1'b1);
		check(reg_rdata, exp);
		@(posedge clk);
		#1;
	endtask : rd

	function automatic logic [31:0] ctl(input logic [1:0] md, input logic [2:0] g, input logic [2:0] l);
		return {22'h0, md, 1'b0, g, 1'b0, l};
	endfunction : ctl

	// gap of zero skips the spacing check
	task automatic take(input chan_t c0, input gain_t g0, input chan_t c1, input gain_t g1, input int gap);
		int t;
		int now;
		t = 0;
		while (m1_i.ch_q.size() == 0 && t < 40) begin
			@(posedge clk);
			#1;
			t++;
		end
		if (m0_i.ch_q.size() == 0 || m1_i.ch_q.size() == 0) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, 0, 1);
			results();
		end
		now = m0_i.t_q.pop_front();
		if (gap > 0) check(now - last_t, gap);
		last_t = now;
		void'(m1_i.t_q.pop_front());
		check(m0_i.ch_q.pop_front(), c0);
		check(m0_i.g_q.pop_front(), g0);
		check(m1_i.ch_q.pop_front(), c1);
		check(m1_i.g_q.pop_front(), g1);
	endtask : take

	task automatic quiet(input int n);
		repeat (n) @(posedge clk);
		#1;
		check(m0_i.ch_q.size() + m1_i.ch_q.size(), 0);
	endtask : quiet

	task automatic edge_start();
		ext_start_pin = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		ext_start_pin = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask : edge_start

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(`REG_START_DIV, 32'h0);
		rd(`REG_BASE_CLK, `BASE_CLK_HZ);
		wr(`REG_START_DIV, 32'h0000_0009);
		rd(`REG_START_DIV, 32'h0000_0009);
		wr(`REG_SCAN_DIV, 32'h0000_0003);
		rd(`REG_SCAN_DIV, 32'h0000_0003);
		wr(`REG_GAIN_HI, 32'h0123_4567);
		rd(`REG_GAIN_HI, 32'h0123_4567);
		wr(`REG_CTRL1, 32'hfffa_ffff);
		rd(`REG_CTRL1, 32'h0000_0377);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0);
	endtask : t_regs

	task automatic t_modes();
		logic [1:0] m;
		logic [1:0] m1;
		chan_t      c0;
		chan_t      c1;
		ext_start_enable = 1'b1;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			m1 = (m == 2'h1) ? 2'h1 : m ^ 2'h2;
			ext_start_rising = ~i[0];
			reset_dut();
			wr(`REG_GAIN_LO, 32'h7654_3210);
			wr(`REG_GAIN_HI, 32'h0123_4567);
			wr(`REG_CTRL1, ctl(m1, 3'h5, 3'h2));
			wr(`REG_CTRL0, ctl(m, 3'h3, 3'h2));
			for (int k = 0; k < 4; k++) begin
				if (m == 2'h1 && k == 2) wr(`REG_CTRL0, ctl(m, 3'h6, 3'h2));
				edge_start();
				c0 = (m == 2'h0) ? 3'h2 : 3'(k % 3);
				c1 = (m1 == 2'h0) ? 3'h2 : 3'(k % 3);
				take(c0, (m == 2'h2) ? 4'(c0) : ((m == 2'h1 && k >= 2) ? 4'h6 : 4'h3),
					c1, (m1 == 2'h2) ? 4'(7 - c1) : 4'h5, 0);
			end
		end
		ext_start_enable = 1'b0;
	endtask : t_modes

	task automatic t_periodic();
		reset_dut();
		wr(`REG_START_DIV, 32'h5);
		wr(`REG_CTRL1, ctl(2'h3, 3'h1, 3'h3));
		wr(`REG_CTRL0, ctl(2'h3, 3'h2, 3'h3) | 32'h0001_0000);
		for (int k = 0; k < 3; k++) take(3'(k), 4'h2, 3'(k), 4'h1, (k > 0) ? 5 : 0);
		wr(`REG_CTRL0, ctl(2'h3, 3'h2, 3'h3));
		quiet(20);
		// second register cannot start a periodic run
		wr(`REG_CTRL1, ctl(2'h3, 3'h1, 3'h3) | 32'h0001_0000);
		quiet(20);
		wr(`REG_START_DIV, 32'h0);
		wr(`REG_CTRL1, ctl(2'h3, 3'h1, 3'h3) | 32'h0001_0000);
		take(3'h0, 4'h2, 3'h0, 4'h1, 0);
		quiet(20);
	endtask : t_periodic

	task automatic t_trigger();
		reset_dut();
		ext_trig_enable = 1'b1;
		wr(`REG_START_DIV, 32'h4);
		ext_trig_pin = 1'b0;
		quiet(10);
		ext_trig_pin = 1'b1;
		wr(`REG_CTRL1, ctl(2'h3, 3'h7, 3'h1));
		wr(`REG_CTRL0, ctl(2'h3, 3'h7, 3'h1) | 32'h0001_0000);
		quiet(20);
		ext_trig_pin = 1'b0;
		take(3'h0, 4'h7, 3'h0, 4'h7, 0);
		take(3'h1, 4'h7, 3'h1, 4'h7, 4);
		take(3'h0, 4'h7, 3'h0, 4'h7, 4);
		wr(`REG_CTRL0, ctl(2'h3, 3'h7, 3'h1));
		quiet(20);
		ext_trig_enable = 1'b0;
	endtask : t_trigger

	task automatic t_scan();
		reset_dut();
		wr(`REG_SCAN_DIV, 32'h3);
		wr(`REG_GAIN_LO, 32'h7654_3210);
		wr(`REG_GAIN_HI, 32'h0123_4567);
		wr(`REG_CTRL1, ctl(2'h2, 3'h0, 3'h3));
		wr(`REG_CTRL0, ctl(2'h2, 3'h0, 3'h3) | 32'h0005_0000);
		for (int k = 0; k < 4; k++) take(3'(k), 4'(k), 3'(k), 4'(7 - k), (k > 0) ? 3 : 0);
		quiet(20);
		wr(`REG_CTRL1, ctl(2'h2, 3'h0, 3'h0));
		wr(`REG_CTRL0, ctl(2'h2, 3'h0, 3'h0) | 32'h0005_0000);
		take(3'h0, 4'h0, 3'h0, 4'h7, 0);
		quiet(20);
		wr(`REG_CTRL1, ctl(2'h0, 3'h1, 3'h3));
		wr(`REG_CTRL0, ctl(2'h0, 3'h2, 3'h3) | 32'h0005_0000);
		take(3'h3, 4'h2, 3'h3, 4'h1, 0);
		quiet(20);
	endtask : t_scan

	////////////////////////////////////////////////////////////////
	initial begin
		reset_dut();
		t_regs();
		t_modes();
		t_periodic();
		t_trigger();
		t_scan();
		results();
	end
endmodule : testbench

bind adc_sequencer_start_control adc_seq_monitor adc_seq_monitor_i (.clk(clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.ext_trig_enable(ext_trig_enable), .ext_start_enable(ext_start_enable), .conv_start(conv_start),
	.conv_channel(conv_channel), .conv_gain(conv_gain));
